// ===== inc/apc_pkg.sv
// Constants and types for the amplifier panel controller
// Functional notes
// R1: Polarity key press toggles output polarity
// R2: Polarity key LED lit while reversed
// R3: Polarity key ignored 1 s after change
// R4: Meter drives 11-LED bar, 0-100%
// R5: Plus/minus LEDs follow output sign
// R6: External control: panel key only turns off
// R7: Output key LED lit while output on
// R8: Protection forced off blinks output LED
// R9: Output key press cancels protection trip
// R10: Turn-on refused 2 s after turn-off
// R11: Mute asserted around every relay switch; a forced off from ST_ON drops the relay in the same cycle that mute rises
// R12: Any detector sets overload and its LED
// R13: No turn-on while overload indicator lit
// R14: Overvoltage while on: off and trip
// R15: Other overload 10 s: off and trip
// R16: Switches 1,4,9,8 load output, ext, bias, impedance
// R17: Switches 2,3 load power-on gain
// R18: Switch 5 loads power-on polarity
// R19: Switches 6,7 load input A, B enables
// R20: External contact closed requests on, open off
// R21: Overload contact closed while overload active
// R22: Gain, input, impedance, bias keys lock 1 s
// R23: Overload 60 s: disable mode, LED blinks
// R24: Persistence timers restart when overload clears
package apc_pkg;
  localparam longint unsigned CLK_HZ = 64'h5f5e100;
  localparam longint unsigned MS_DIV = 64'h3e8;
  localparam longint unsigned US_DIV = 64'hf4240;
  localparam longint unsigned KEY_LOCK_MS = 64'h3e8;
  localparam longint unsigned OFF_LOCK_MS = 64'h7d0;
  localparam longint unsigned TRIP_S = 64'ha;
  localparam longint unsigned DISABLE_S = 64'h3c;
  localparam longint unsigned BLINK_MS = 64'hfa;
  localparam longint unsigned MUTE_US = 64'ha;
  localparam int TW = 33;
  localparam logic [TW-1:0] KEY_LOCK_CYC = TW'(KEY_LOCK_MS * CLK_HZ / MS_DIV);
  localparam logic [TW-1:0] OFF_LOCK_CYC = TW'(OFF_LOCK_MS * CLK_HZ / MS_DIV);
  localparam logic [TW-1:0] TRIP_CYC = TW'(TRIP_S * CLK_HZ);
  localparam logic [TW-1:0] DISABLE_CYC = TW'(DISABLE_S * CLK_HZ);
  localparam logic [TW-1:0] BLINK_CYC = TW'(BLINK_MS * CLK_HZ / MS_DIV);
  localparam int MW = 11;
  localparam logic [MW-1:0] MUTE_CYC = MW'(MUTE_US * CLK_HZ / US_DIV);
  localparam logic [MW-1:0] MUTE_TOTAL = MW'(2 * MUTE_US * CLK_HZ / US_DIV);
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_SETTING = 8'h08;
  localparam int DIP_OUT = 0;
  localparam int DIP_GAIN_LO = 1;
  localparam int DIP_GAIN_HI = 2;
  localparam int DIP_EXT = 3;
  localparam int DIP_POL = 4;
  localparam int DIP_INA = 5;
  localparam int DIP_INB = 6;
  localparam int DIP_IMP = 7;
  localparam int DIP_BIAS = 8;
  localparam int LK_POL = 0;
  localparam int LK_GAIN = 1;
  localparam int LK_INA = 2;
  localparam int LK_INB = 3;
  localparam int LK_IMP = 4;
  localparam int LK_BIAS = 5;
  localparam int NLOCK = 6;
  localparam int METER_LEDS = 11;
  localparam logic [6:0] METER_STEP = 7'h0a;

  typedef enum logic [1:0] {
    GAIN_X1 = 2'h0,
    GAIN_X10 = 2'h1,
    GAIN_X20 = 2'h2,
    GAIN_X50 = 2'h3
  } apc_gain_e;

  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_MUTE_ON = 2'h1,
    ST_ON = 2'h3,
    ST_MUTE_OFF = 2'h2
  } apc_out_e;

  typedef struct packed {
    logic outputKey;
    logic biasKey;
    logic impKey;
    logic inBKey;
    logic inAKey;
    logic gainKey;
    logic polarityInvertKey;
  } apc_keys_s;

  typedef struct packed {
    logic biasOn;
    logic imp50;
    logic inputBOn;
    logic inputAOn;
    apc_gain_e gain;
    logic polarityReversed;
    logic extCtrl;
  } apc_setting_s;

  typedef struct packed {
    logic overVoltage;
    logic overTemp;
    logic overLoss;
    logic overCurrent;
  } apc_detect_s;

  typedef struct packed {
    logic disabled;
    logic tripped;
    logic overload;
    logic offLock;
    logic relayOn;
    logic mute;
    apc_out_e state;
  } apc_status_s;
endpackage : apc_pkg

// ===== src/apc_timer.sv
// Saturating run-time counter with a done level
`timescale 1ns/100ps
module apc_timer #(
  parameter int W = apc_pkg::TW
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic done
);
  import apc_pkg::*;

  logic [W-1:0] count_q, count_d;
  logic done_d;

  // Count only while run is high, clear otherwise
  always_comb
  begin
    count_d = count_q;
    if (!run)
    begin
      count_d = '0;
    end
    else if (count_q != limit)
    begin
      count_d = count_q + 1'b1;
    end
    done_d = run && (count_d == limit);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_q <= '0;
      done <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      done <= done_d;
    end
  end
endmodule : apc_timer

// ===== src/apc_panel_control.sv
// Panel, output and protection control of the amplifier
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module apc_panel_control #(
  parameter logic [apc_pkg::TW-1:0] KEY_LOCK_CYCLES = apc_pkg::KEY_LOCK_CYC,
  parameter logic [apc_pkg::TW-1:0] OFF_LOCK_CYCLES = apc_pkg::OFF_LOCK_CYC,
  parameter logic [apc_pkg::TW-1:0] TRIP_CYCLES = apc_pkg::TRIP_CYC,
  parameter logic [apc_pkg::TW-1:0] DISABLE_CYCLES = apc_pkg::DISABLE_CYC,
  parameter logic [apc_pkg::TW-1:0] BLINK_CYCLES = apc_pkg::BLINK_CYC
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [apc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [8:0] dipDown,
  input wire apc_pkg::apc_keys_s panelKeys,
  input wire apc_pkg::apc_detect_s detect,
  input wire logic extOnClosed,
  input wire logic [6:0] meterLevel,
  input wire logic levelPositive,
  input wire logic levelNegative,
  output apc_pkg::apc_setting_s setting,
  output logic relayOn,
  output logic muteMonitor,
  output logic outputKeyLed,
  output logic polarityKeyLed,
  output logic overloadIndicator,
  output logic overloadContactClosed,
  output logic [apc_pkg::METER_LEDS-1:0] meterBar,
  output logic meterPlusLed,
  output logic meterMinusLed
);
  import apc_pkg::*;

  // Thermometer code for the meter bar
  function automatic logic [METER_LEDS-1:0] bar_of(input logic [6:0] level);
    logic [METER_LEDS-1:0] b;
    logic [6:0] thr;
    b = '0;
    thr = '0;
    for (int i = 0; i < METER_LEDS; i++)
    begin
      b[i] = (level >= thr);
      thr = thr + METER_STEP;
    end
    return b;
  endfunction : bar_of

  // Control state
  apc_setting_s set_q, set_d;
  apc_out_e state_q, state_d;
  logic [MW-1:0] muteCnt_q, muteCnt_d;
  logic init_q, init_d;
  logic relay_q, relay_d;
  logic mute_q, mute_d;
  logic tripped_q, tripped_d;
  logic disabled_q, disabled_d;
  logic offLock_q, offLock_d;
  logic extPrev_q, extPrev_d;
  apc_keys_s keysPrev_q, keysPrev_d;
  logic [NLOCK-1:0] lockBusy_q, lockBusy_d;
  logic blinkPhase_q, blinkPhase_d;

  // Indicator state
  logic outLed_q, outLed_d;
  logic polLed_q, polLed_d;
  logic ovlLed_q, ovlLed_d;
  logic ovlContact_q, ovlContact_d;
  logic [METER_LEDS-1:0] bar_q, bar_d;
  logic plus_q, plus_d;
  logic minus_q, minus_d;

  // Bus state
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  apc_keys_s softKeys_q, softKeys_d;

  // Timer outputs and shared terms
  logic [NLOCK-1:0] lockDone;
  logic offLockDone;
  logic tripDone;
  logic disableDone;
  logic blinkDone;
  logic overloadNow;
  logic isOn;
  logic onAllowed;
  logic forceOff;
  logic onReq;
  logic offReq;
  apc_keys_s press;
  apc_status_s status;

  assign overloadNow = |detect; // see R12
  assign isOn = (state_q == ST_ON) || (state_q == ST_MUTE_ON);
  assign press = apc_keys_s'((panelKeys & ~keysPrev_q) | softKeys_q);
  assign onAllowed = !overloadNow && !offLock_q && !disabled_q && !tripped_q; // see R13 see R10
  assign forceOff = isOn && (disabled_q || detect.overVoltage || tripDone); // see R14 see R15 see R23
  assign status = '{disabled: disabled_q, tripped: tripped_q, overload: overloadNow, offLock: offLock_q,
                    relayOn: relay_q, mute: mute_q, state: state_q};

  // Per-key lockouts after a setting change
  for (genvar i = 0; i < NLOCK; i++)
  begin : g_lock
    apc_timer #(.W(TW)) u_lock (
      .clk(clk),
      .reset(reset),
      .run(lockBusy_q[i]),
      .limit(KEY_LOCK_CYCLES),
      .done(lockDone[i])
    );
  end

  apc_timer #(.W(TW)) u_off_lock (
    .clk(clk),
    .reset(reset),
    .run(offLock_q),
    .limit(OFF_LOCK_CYCLES),
    .done(offLockDone)
  );

  // Persistence timers clear whenever all detectors drop
  apc_timer #(.W(TW)) u_trip (
    .clk(clk),
    .reset(reset),
    .run(overloadNow), // see R24
    .limit(TRIP_CYCLES),
    .done(tripDone)
  );

  apc_timer #(.W(TW)) u_disable (
    .clk(clk),
    .reset(reset),
    .run(overloadNow), // see R24
    .limit(DISABLE_CYCLES),
    .done(disableDone)
  );

  apc_timer #(.W(TW)) u_blink (
    .clk(clk),
    .reset(reset),
    .run(!blinkDone),
    .limit(BLINK_CYCLES),
    .done(blinkDone)
  );

  // Settings, requests and protection flags
  always_comb
  begin
    set_d = set_q;
    init_d = 1'b0;
    tripped_d = tripped_q;
    disabled_d = disabled_q;
    keysPrev_d = panelKeys;
    extPrev_d = extOnClosed;
    lockBusy_d = lockBusy_q & ~lockDone;
    onReq = 1'b0;
    offReq = 1'b0;
    blinkPhase_d = blinkDone ? !blinkPhase_q : blinkPhase_q;
    if (init_q)
    begin
      set_d.extCtrl = dipDown[DIP_EXT]; // see R16
      set_d.biasOn = dipDown[DIP_BIAS]; // see R16
      set_d.imp50 = dipDown[DIP_IMP]; // see R16
      set_d.gain = apc_gain_e'({dipDown[DIP_GAIN_HI], dipDown[DIP_GAIN_LO]}); // see R17
      set_d.polarityReversed = dipDown[DIP_POL]; // see R18
      set_d.inputAOn = dipDown[DIP_INA]; // see R19
      set_d.inputBOn = dipDown[DIP_INB]; // see R19
      onReq = dipDown[DIP_OUT]; // see R16
    end
    else if (!disabled_q)
    begin
      if (press.polarityInvertKey && !lockBusy_q[LK_POL])
      begin
        set_d.polarityReversed = !set_q.polarityReversed; // see R1
        lockBusy_d[LK_POL] = 1'b1; // see R3
      end
      if (press.gainKey && !lockBusy_q[LK_GAIN])
      begin
        set_d.gain = apc_gain_e'(set_q.gain + 2'h1);
        lockBusy_d[LK_GAIN] = 1'b1; // see R22
      end
      if (press.inAKey && !lockBusy_q[LK_INA])
      begin
        set_d.inputAOn = !set_q.inputAOn;
        lockBusy_d[LK_INA] = 1'b1; // see R22
      end
      if (press.inBKey && !lockBusy_q[LK_INB])
      begin
        set_d.inputBOn = !set_q.inputBOn;
        lockBusy_d[LK_INB] = 1'b1; // see R22
      end
      if (press.impKey && !lockBusy_q[LK_IMP])
      begin
        set_d.imp50 = !set_q.imp50;
        lockBusy_d[LK_IMP] = 1'b1; // see R22
      end
      if (press.biasKey && !lockBusy_q[LK_BIAS])
      begin
        set_d.biasOn = !set_q.biasOn;
        lockBusy_d[LK_BIAS] = 1'b1; // see R22
      end
      if (press.outputKey)
      begin
        if (tripped_q)
        begin
          tripped_d = 1'b0; // see R9
        end
        else if (isOn)
        begin
          offReq = 1'b1;
        end
        else if (!set_q.extCtrl)
        begin
          onReq = 1'b1; // see R6
        end
      end
      if (set_q.extCtrl && extOnClosed && !extPrev_q)
      begin
        onReq = 1'b1; // see R20
      end
      if (set_q.extCtrl && !extOnClosed && extPrev_q)
      begin
        offReq = 1'b1; // see R20
      end
    end
    if (disableDone)
    begin
      disabled_d = 1'b1; // see R23
    end
    if (forceOff && !disabled_q)
    begin
      tripped_d = 1'b1; // see R8
    end
  end

  // Output relay sequencing with mute window
  always_comb
  begin
    state_d = state_q;
    muteCnt_d = muteCnt_q;
    relay_d = relay_q;
    offLock_d = offLock_q && !offLockDone;
    case (state_q)
      ST_OFF:
      begin
        if (onReq && onAllowed)
        begin
          state_d = ST_MUTE_ON;
          muteCnt_d = '0;
        end
      end
      ST_MUTE_ON:
      begin
        if (forceOff || offReq)
        begin
          state_d = ST_MUTE_OFF;
          muteCnt_d = '0;
          relay_d = 1'b0;
        end
        else
        begin
          muteCnt_d = muteCnt_q + 1'b1;
          relay_d = (muteCnt_d >= MUTE_CYC); // see R11
          if (muteCnt_d == MUTE_TOTAL)
          begin
            state_d = ST_ON;
          end
        end
      end
      ST_ON:
      begin
        if (forceOff)
        begin
          state_d = ST_MUTE_OFF;
          muteCnt_d = '0;
          relay_d = 1'b0; // see R14
        end
        else if (offReq)
        begin
          state_d = ST_MUTE_OFF;
          muteCnt_d = '0;
        end
      end
      ST_MUTE_OFF:
      begin
        muteCnt_d = muteCnt_q + 1'b1;
        relay_d = relay_q && (muteCnt_d < MUTE_CYC) && !detect.overVoltage; // see R11 see R14
        if (muteCnt_d == MUTE_TOTAL)
        begin
          state_d = ST_OFF;
          offLock_d = 1'b1; // see R10
        end
      end
      default:
      begin
        state_d = ST_OFF;
        relay_d = 1'b0;
      end
    endcase
    mute_d = (state_d == ST_MUTE_ON) || (state_d == ST_MUTE_OFF); // see R11
  end

  // Indicators and contacts
  always_comb
  begin
    outLed_d = tripped_d ? blinkPhase_q : relay_d; // see R7 see R8
    polLed_d = set_d.polarityReversed; // see R2
    ovlLed_d = disabled_q ? blinkPhase_q : overloadNow; // see R12 see R23
    ovlContact_d = overloadNow || disabled_q; // see R21
    bar_d = bar_of(meterLevel); // see R4
    plus_d = levelPositive; // see R5
    minus_d = levelNegative; // see R5
  end

  // APB slave with one wait state
  always_comb
  begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = '0;
    softKeys_d = '0;
    if (psel && penable && !pready_q)
    begin
      pready_d = 1'b1;
      if (paddr == ADDR_CTRL)
      begin
        prdata_d = '0;
      end
      else if (paddr == ADDR_STATUS)
      begin
        prdata_d = 32'(status);
      end
      else if (paddr == ADDR_SETTING)
      begin
        prdata_d = 32'(set_q);
      end
      else
      begin
        pslverr_d = 1'b1;
      end
    end
    else if (psel && penable && pready_q && pwrite && !pslverr_q && paddr == ADDR_CTRL)
    begin
      softKeys_d = apc_keys_s'(pwdata[$bits(apc_keys_s)-1:0]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      set_q <= '0;
      init_q <= 1'b1;
      tripped_q <= 1'b0;
      disabled_q <= 1'b0;
      keysPrev_q <= '0;
      extPrev_q <= 1'b0;
      lockBusy_q <= '0;
      blinkPhase_q <= 1'b0;
      state_q <= ST_OFF;
      muteCnt_q <= '0;
      relay_q <= 1'b0;
      mute_q <= 1'b0;
      offLock_q <= 1'b0;
      outLed_q <= 1'b0;
      polLed_q <= 1'b0;
      ovlLed_q <= 1'b0;
      ovlContact_q <= 1'b0;
      bar_q <= '0;
      plus_q <= 1'b0;
      minus_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      softKeys_q <= '0;
    end
    else
    begin
      set_q <= set_d;
      init_q <= init_d;
      tripped_q <= tripped_d;
      disabled_q <= disabled_d;
      keysPrev_q <= keysPrev_d;
      extPrev_q <= extPrev_d;
      lockBusy_q <= lockBusy_d;
      blinkPhase_q <= blinkPhase_d;
      state_q <= state_d;
      muteCnt_q <= muteCnt_d;
      relay_q <= relay_d;
      mute_q <= mute_d;
      offLock_q <= offLock_d;
      outLed_q <= outLed_d;
      polLed_q <= polLed_d;
      ovlLed_q <= ovlLed_d;
      ovlContact_q <= ovlContact_d;
      bar_q <= bar_d;
      plus_q <= plus_d;
      minus_q <= minus_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      softKeys_q <= softKeys_d;
    end
  end

  assign setting = set_q;
  assign relayOn = relay_q;
  assign muteMonitor = mute_q;
  assign outputKeyLed = outLed_q;
  assign polarityKeyLed = polLed_q;
  assign overloadIndicator = ovlLed_q;
  assign overloadContactClosed = ovlContact_q;
  assign meterBar = bar_q;
  assign meterPlusLed = plus_q;
  assign meterMinusLed = minus_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule : apc_panel_control

// ===== verif/apc_panel_control_monitor.sv
// Port checker for the panel controller
`timescale 1ns/100ps
module apc_panel_control_monitor
(
  input wire logic clk,
  input wire logic reset,
  input wire apc_pkg::apc_detect_s detect,
  input wire apc_pkg::apc_setting_s setting,
  input wire logic extOnClosed,
  input wire logic [6:0] meterLevel,
  input wire logic levelPositive,
  input wire logic levelNegative,
  input wire logic relayOn,
  input wire logic muteMonitor,
  input wire logic outputKeyLed,
  input wire logic polarityKeyLed,
  input wire logic overloadIndicator,
  input wire logic overloadContactClosed,
  input wire logic [apc_pkg::METER_LEDS-1:0] meterBar,
  input wire logic meterPlusLed,
  input wire logic meterMinusLed
);
  import apc_pkg::*;
  logic [METER_LEDS-1:0] expBar;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Bar pattern expected from the level
  always_comb
  begin
    for (int k = 0; k < METER_LEDS; k++)
      expBar[k] = meterLevel >= 7'(k) * METER_STEP;
  end
  a_pol_led: assert property ($stable(setting.polarityReversed)[*2] |-> polarityKeyLed == setting.polarityReversed)
    else $error("polarity led wrong");
  a_out_led: assert property (relayOn && $past(relayOn) |-> outputKeyLed)
    else $error("output led dark while on");
  a_mute_relay: assert property ($changed(relayOn) |-> ##[0:1] muteMonitor)
    else $error("relay switched unmuted");
  a_ovl_led: assert property ($rose(|detect) ##1 (|detect)[*2] |-> overloadIndicator)
    else $error("overload led dark");
  a_ovl_contact: assert property ((|detect)[*3] |-> overloadContactClosed)
    else $error("overload contact open");
  a_on_blocked: assert property (overloadContactClosed && $past(overloadContactClosed) && !relayOn && !muteMonitor
    |=> !muteMonitor)
    else $error("turn-on during overload");
  a_trip_ov: assert property (relayOn && detect.overVoltage |-> ##[1:3] !relayOn)
    else $error("overvoltage left output on");
  a_ext_only: assert property (setting.extCtrl && !relayOn && !muteMonitor && !extOnClosed && !$past(extOnClosed)
    |=> !muteMonitor)
    else $error("panel turned output on");
  a_meter_bar: assert property (!$past(reset) && !$past(reset, 2) |-> meterBar == $past(expBar))
    else $error("meter bar wrong");
  a_sign_leds: assert property (!$past(reset) && !$past(reset, 2)
    |-> {meterPlusLed, meterMinusLed} == $past({levelPositive, levelNegative}))
    else $error("sign leds wrong");
  c_turn_on: cover property ($rose(relayOn));
  c_forced_off: cover property ($fell(relayOn) && overloadContactClosed);
  c_ext_on: cover property (setting.extCtrl && $rose(relayOn));
endmodule : apc_panel_control_monitor

// ===== verif/apc_panel_model.sv
// Front panel keys and external contact model
`timescale 1ns/100ps
module apc_panel_model
(
  input wire logic clk,
  input wire apc_pkg::apc_keys_s pressCmd,
  input wire logic extCmd,
  output apc_pkg::apc_keys_s panelKeys,
  output logic extOnClosed
);
  import apc_pkg::*;
  logic [1:0] holdQ = 2'h0;
  apc_keys_s keysQ = '0;
  // Key held a few cycles, then released
  always_ff @(posedge clk)
  begin
    if (pressCmd != '0)
    begin
      keysQ <= pressCmd;
      holdQ <= 2'h3;
    end
    else if (holdQ != 2'h0)
      holdQ <= holdQ - 2'h1;
    else
      keysQ <= '0;
    extOnClosed <= extCmd;
  end
  assign panelKeys = keysQ;
endmodule : apc_panel_model

// ===== verif/apc_panel_control_test.sv
// Self-checking bench for the panel controller
`timescale 1ns/100ps
module apc_panel_control_test;
  import apc_pkg::*;
  localparam int WKL = 24;
  localparam int WOL = 50;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, extCmd = 1'h0, extOnClosed;
  logic [8:0] dipDown = 9'h0b2;
  apc_keys_s panelKeys, pressCmd = '0;
  apc_detect_s detect = '0;
  logic [6:0] meterLevel = '0;
  logic [6:0] lv [5] = '{7'h00, 7'h09, 7'h0a, 7'h37, 7'h64};
  logic levelPositive = 1'h0, levelNegative = 1'h0;
  apc_setting_s setting;
  logic relayOn, muteMonitor, outputKeyLed, polarityKeyLed, overloadIndicator, overloadContactClosed;
  logic [METER_LEDS-1:0] meterBar, eb;
  logic meterPlusLed, meterMinusLed;
  int nErrors = 0, checksDone = 0, cyc = 0;
  apc_panel_control #(.KEY_LOCK_CYCLES(33'h14), .OFF_LOCK_CYCLES(33'h28), .TRIP_CYCLES(33'h64),
    .DISABLE_CYCLES(33'h12c), .BLINK_CYCLES(33'h5)) apc_panel_control_i (.clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dipDown, .panelKeys, .detect, .extOnClosed,
    .meterLevel, .levelPositive, .levelNegative, .setting, .relayOn, .muteMonitor, .outputKeyLed,
    .polarityKeyLed, .overloadIndicator, .overloadContactClosed, .meterBar, .meterPlusLed, .meterMinusLed);
  apc_panel_model apc_panel_model_i (.clk, .pressCmd, .extCmd, .panelKeys, .extOnClosed);
  always #5 clk = ~clk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      nErrors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e)
    begin
      nErrors++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic press(input logic [6:0] k);
    pressCmd <= apc_keys_s'(k);
    @(posedge clk);
    pressCmd <= '0;
    wt(6);
  endtask : press
  task automatic settle();
    wt(6);
    while (muteMonitor !== 1'h0)
      @(posedge clk);
    wt(2);
  endtask : settle
  task automatic blink(input logic sel);
    int ones;
    ones = 0;
    repeat (16)
    begin
      @(posedge clk);
      ones += int'(sel ? overloadIndicator : outputKeyLed);
    end
    chk(32'h1, 32'(ones > 0 && ones < 16));
  endtask : blink
  initial
  begin
    wt(16);
    reset <= 1'h0;
    wt(4);
    chk(32'h56, 32'(setting));
    chk(32'h1, 32'(polarityKeyLed));
    apb(1'h0, ADDR_SETTING, 32'h0);
    chk(32'h56, rd);
    apb(1'h0, 8'h0c, 32'h0);
    chk(32'h1, 32'(err));
    $display("test power-on done");
    press(7'h01);
    chk(32'h0, 32'(polarityKeyLed));
    press(7'h01);
    chk(32'h54, 32'(setting));
    wt(WKL);
    apb(1'h1, ADDR_CTRL, 32'h1);
    wt(4);
    chk(32'h1, 32'(polarityKeyLed));
    press(7'h02);
    press(7'h02);
    chk(32'h5a, 32'(setting));
    wt(WKL);
    press(7'h02);
    apb(1'h1, ADDR_CTRL, 32'h3c);
    wt(4);
    apb(1'h0, ADDR_SETTING, 32'h0);
    chk(32'hae, rd);
    $display("test keys done");
    press(7'h40);
    chk(32'h1, 32'(muteMonitor));
    settle();
    chk(32'h1, 32'(outputKeyLed));
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(32'h0b, rd);
    foreach (lv[i])
    begin
      meterLevel <= lv[i];
      wt(3);
      for (int k = 0; k < METER_LEDS; k++)
        eb[k] = lv[i] >= 7'(10 * k);
      chk(32'(eb), 32'(meterBar));
    end
    levelPositive <= 1'h1;
    wt(3);
    chk(32'h2, 32'({meterPlusLed, meterMinusLed}));
    levelNegative <= 1'h1;
    wt(3);
    chk(32'h3, 32'({meterPlusLed, meterMinusLed}));
    $display("test meter done");
    repeat (2)
    begin
      detect.overTemp <= 1'h1;
      wt(60);
      detect.overTemp <= 1'h0;
      wt(5);
    end
    chk(32'h1, 32'(relayOn));
    detect.overTemp <= 1'h1;
    wt(4);
    chk(32'h3, 32'({overloadIndicator, overloadContactClosed}));
    wt(106);
    chk(32'h0, 32'(relayOn));
    blink(1'h0);
    detect.overTemp <= 1'h0;
    wt(4);
    press(7'h40);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(32'h0, 32'(rd[6]));
    settle();
    press(7'h40);
    chk(32'h0, 32'(muteMonitor));
    wt(WOL);
    detect.overCurrent <= 1'h1;
    wt(4);
    press(7'h40);
    chk(32'h0, 32'(muteMonitor));
    detect.overCurrent <= 1'h0;
    wt(4);
    press(7'h40);
    settle();
    chk(32'h1, 32'(relayOn));
    detect.overVoltage <= 1'h1;
    wt(4);
    chk(32'h0, 32'(relayOn));
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(32'h1, 32'(rd[6]));
    detect.overVoltage <= 1'h0;
    press(7'h40);
    settle();
    $display("test protection done");
    detect.overTemp <= 1'h1;
    wt(310);
    detect.overTemp <= 1'h0;
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(32'h1, 32'(rd[7]));
    blink(1'h1);
    press(7'h40);
    chk(32'h0, 32'(muteMonitor));
    $display("test disable done");
    dipDown <= 9'h009;
    reset <= 1'h1;
    wt(16);
    reset <= 1'h0;
    settle();
    chk(32'h1, 32'(relayOn));
    chk(32'h01, 32'(setting));
    extCmd <= 1'h1;
    wt(4);
    extCmd <= 1'h0;
    settle();
    chk(32'h0, 32'(relayOn));
    wt(WOL);
    extCmd <= 1'h1;
    settle();
    chk(32'h1, 32'(relayOn));
    press(7'h40);
    settle();
    chk(32'h0, 32'(relayOn));
    wt(WOL);
    press(7'h40);
    chk(32'h0, 32'(muteMonitor));
    $display("test external done");
    final_report();
  end
endmodule : apc_panel_control_test
bind apc_panel_control apc_panel_control_monitor apc_panel_control_monitor_i (.clk, .reset, .detect, .setting,
  .extOnClosed, .meterLevel, .levelPositive, .levelNegative, .relayOn, .muteMonitor, .outputKeyLed,
  .polarityKeyLed, .overloadIndicator, .overloadContactClosed, .meterBar, .meterPlusLed, .meterMinusLed);
